// >>> hdl/irq_funnel_pkg.sv
// Constants, register map and field layout of the interrupt funnel
// How it works
// R1 - USB events merge into one flag bit 5
// R2 - USB sources own flag/enable, one shared priority
// R3 - Flags set regardless of any enable bit; bit 5 here sets only from USB sources whose enable is set
// R4 - No priority: bit 7 gates every interrupt
// R5 - Priority on: bit 7 gates high-priority interrupts
// R6 - No priority: bit 6 gates peripheral interrupts
// R7 - Priority on: bit 6 gates low-priority interrupts
// R8 - Timer-0 overflow sets bit 2, enable bit 5
// R9 - Selected line-0 edge sets bit 1, enable 4
// R10 - Upper port pin change sets bit 0, enable 3
// R11 - Mismatch keeps setting flag until port read
// R12 - Edge bits 6,5,4: one rising, zero falling
// R13 - Second register: bit 2 timer, bit 0 port priority
// R14 - Third register: priority bits 7,6, enables 4,3
// R15 - Third register flags bits 1,0 stay set
// R16 - Unimplemented bits always read as zero
// R17 - Second register bit 7 disables all pull-ups
// R18 - Software clears flag before enable, after service
// R19 - Priority-enable bit turns on two priority levels
// R20 - Vector 000008h high, 000018h low, else 000008h
// R21 - Accept clears applicable global enable, return restores
// R22 - High preempts low; low waits during high
// R23 - Request is flag, enable, group and global enable
// R24 - Reset values: 0xF5, 0xC0 and all zero
package irq_funnel_pkg;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int EXT_N    = 3;
	localparam int PORT_N   = 4;
	localparam int USB_N    = 8;
	localparam int VEC_W    = 21;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] A_GCTL   = 8'h00;
	localparam logic [ADDR_W-1:0] A_ECTL   = 8'h04;
	localparam logic [ADDR_W-1:0] A_XCTL   = 8'h08;
	localparam logic [ADDR_W-1:0] A_PFLAG2 = 8'h0C;
	localparam logic [ADDR_W-1:0] A_PEN2   = 8'h10;
	localparam logic [ADDR_W-1:0] A_PPRI2  = 8'h14;
	localparam logic [ADDR_W-1:0] A_RSTCTL = 8'h18;
	localparam logic [ADDR_W-1:0] A_USBF   = 8'h1C;
	localparam logic [ADDR_W-1:0] A_USBE   = 8'h20;
	localparam logic [ADDR_W-1:0] A_PORT   = 8'h24;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h28;

	// interrupt_global_control fields
	localparam int GC_HIEN = 7;
	localparam int GC_LOEN = 6;
	localparam int GC_T0E  = 5;
	localparam int GC_X0E  = 4;
	localparam int GC_PCE  = 3;
	localparam int GC_T0F  = 2;
	localparam int GC_X0F  = 1;
	localparam int GC_PCF  = 0;
	// edge_priority_pullup_control fields
	localparam int EC_PUD   = 7;
	localparam int EC_EDGE0 = 6;
	localparam int EC_EDGE1 = 5;
	localparam int EC_EDGE2 = 4;
	localparam int EC_T0P   = 2;
	localparam int EC_PCP   = 0;
	// external_line_interrupt_control fields
	localparam int XC_X2P = 7;
	localparam int XC_X1P = 6;
	localparam int XC_X2E = 4;
	localparam int XC_X1E = 3;
	localparam int XC_X2F = 1;
	localparam int XC_X1F = 0;
	// Device-level peripheral bits and priority scheme bit
	localparam int PF_SBM  = 5;
	localparam int RC_PRIO = 7;
	// Status register fields
	localparam int ST_HI   = 0;
	localparam int ST_LO   = 1;
	localparam int ST_REQ  = 2;

	localparam logic [7:0] GCTL_RST = 8'h00;
	localparam logic [7:0] ECTL_RST = 8'hF5;
	localparam logic [7:0] XCTL_RST = 8'hC0;
	localparam logic [7:0] ECTL_MASK = 8'hF5;
	localparam logic [7:0] XCTL_MASK = 8'hDB;

	localparam logic [VEC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [VEC_W-1:0] VEC_LOW  = 21'h000018;
endpackage

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Pins and synchronised levels
	input  wire logic [W-1:0] pin_async,
	output logic      [W-1:0] pin_sync_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	always_comb begin
		d    = q;
		d.s1 = pin_async;
		d.s2 = q.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_sync_q = q.s2;
endmodule
`default_nettype wire

// >>> hdl/line_event_detect.sv
// Selectable edge detector for the external interrupt lines
`timescale 1ns/1ns
`default_nettype none
module line_event_detect #(
	parameter int N = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Lines and edge choice, one means rising
	input  wire logic [N-1:0] line_async,
	input  wire logic [N-1:0] rising_sel,
	// One-cycle edge events
	output logic      [N-1:0] line_event
);
	typedef struct packed {
		logic [N-1:0] prev;
		logic [2:0]   warm;
	} edge_state_t;

	logic [N-1:0] lvl;
	edge_state_t  q;
	edge_state_t  d;

	pin_sync #(.W(N)) u_sync (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_async  (line_async),
		.pin_sync_q (lvl)
	);

	always_comb begin
		d      = q;
		d.prev = lvl;
		d.warm = {q.warm[1:0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Rising when selected, falling otherwise; held off until prev holds a real pin level,
	// so a pin that idles high gives no false edge after reset
	assign line_event = {N{q.warm[2]}}
	                  & ((rising_sel & lvl & ~q.prev) | (~rising_sel & ~lvl & q.prev)); // see R12
endmodule
`default_nettype wire

// >>> hdl/core_interrupt_control_funnel.sv
// Interrupt funnel with APB register access and core request interface
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_funnel (
	// Clock and reset
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	// APB slave
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [irq_funnel_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [irq_funnel_pkg::DATA_W-1:0]     pwdata,
	output logic      [irq_funnel_pkg::DATA_W-1:0]     prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	// Event sources on the same clock
	input  wire logic                                  timer_zero_overflow,
	input  wire logic [irq_funnel_pkg::USB_N-1:0]      serial_bus_events,
	// Asynchronous pins
	input  wire logic [irq_funnel_pkg::EXT_N-1:0]      ext_lines,
	input  wire logic [irq_funnel_pkg::PORT_N-1:0]     upper_port_pins,
	// Port output latch and pull-up control
	input  wire logic [irq_funnel_pkg::PORT_N-1:0]     port_out_latch,
	output logic      [irq_funnel_pkg::PORT_N-1:0]     pullup_on,
	// Processor core
	output logic                                       irq_request,
	output logic      [irq_funnel_pkg::VEC_W-1:0]      irq_vector,
	input  wire logic                                  irq_ack,
	input  wire logic                                  return_from_irq_instr
);
	typedef struct packed {
		logic [7:0]                           gctl;
		logic [7:0]                           ectl;
		logic [7:0]                           xctl;
		logic                                 sbm_flag;
		logic                                 sbm_en;
		logic                                 sbm_pri;
		logic                                 prio_en;
		logic [irq_funnel_pkg::USB_N-1:0]     usb_flag;
		logic [irq_funnel_pkg::USB_N-1:0]     usb_en;
		logic [irq_funnel_pkg::PORT_N-1:0]    port_latch;
		logic                                 hi_busy;
		logic                                 lo_busy;
		logic                                 irq_q;
		logic [irq_funnel_pkg::VEC_W-1:0]     vec_q;
		logic [irq_funnel_pkg::PORT_N-1:0]    pullup_q;
		logic [irq_funnel_pkg::DATA_W-1:0]    prdata_q;
		logic                                 pslverr_q;
	} funnel_state_t;

	funnel_state_t                            q;
	funnel_state_t                            s;
	logic [irq_funnel_pkg::EXT_N-1:0]         ext_event;
	logic [irq_funnel_pkg::EXT_N-1:0]         ext_rising;
	logic [irq_funnel_pkg::PORT_N-1:0]        port_now;
	logic                                     wr_acc;
	logic                                     rd_acc;
	logic                                     setup;
	logic                                     mismatch;
	logic                                     usb_any;
	logic                                     src_t0;
	logic                                     src_x0;
	logic                                     src_pc;
	logic                                     src_x1;
	logic                                     src_x2;
	logic                                     src_usb;
	logic                                     any_hi;
	logic                                     any_lo;
	logic                                     req_hi;
	logic                                     req_lo;
	logic [7:0]                               rd_byte;
	logic                                     rd_hit;

	// Line i uses edge bit 6 - i
	assign ext_rising = {q.ectl[irq_funnel_pkg::EC_EDGE2],
	                     q.ectl[irq_funnel_pkg::EC_EDGE1],
	                     q.ectl[irq_funnel_pkg::EC_EDGE0]}; // see R12

	line_event_detect #(.N(irq_funnel_pkg::EXT_N)) u_ext (
		.pclk       (pclk),
		.presetn    (presetn),
		.line_async (ext_lines),
		.rising_sel (ext_rising),
		.line_event (ext_event)
	);

	pin_sync #(.W(irq_funnel_pkg::PORT_N)) u_port (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_async  (upper_port_pins),
		.pin_sync_q (port_now)
	);

	assign setup    = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign mismatch = (port_now != q.port_latch); // see R10

	// Read data mux, decoded during the setup cycle
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (paddr == irq_funnel_pkg::A_GCTL) begin
			rd_byte = q.gctl;
		end else if (paddr == irq_funnel_pkg::A_ECTL) begin
			rd_byte = q.ectl & irq_funnel_pkg::ECTL_MASK; // see R16
		end else if (paddr == irq_funnel_pkg::A_XCTL) begin
			rd_byte = q.xctl & irq_funnel_pkg::XCTL_MASK; // see R16
		end else if (paddr == irq_funnel_pkg::A_PFLAG2) begin
			rd_byte[irq_funnel_pkg::PF_SBM] = q.sbm_flag;
		end else if (paddr == irq_funnel_pkg::A_PEN2) begin
			rd_byte[irq_funnel_pkg::PF_SBM] = q.sbm_en;
		end else if (paddr == irq_funnel_pkg::A_PPRI2) begin
			rd_byte[irq_funnel_pkg::PF_SBM] = q.sbm_pri;
		end else if (paddr == irq_funnel_pkg::A_RSTCTL) begin
			rd_byte[irq_funnel_pkg::RC_PRIO] = q.prio_en;
		end else if (paddr == irq_funnel_pkg::A_USBF) begin
			rd_byte = q.usb_flag;
		end else if (paddr == irq_funnel_pkg::A_USBE) begin
			rd_byte = q.usb_en;
		end else if (paddr == irq_funnel_pkg::A_PORT) begin
			rd_byte[irq_funnel_pkg::PORT_N-1:0] = port_now;
		end else if (paddr == irq_funnel_pkg::A_STATUS) begin
			rd_byte[irq_funnel_pkg::ST_HI]  = q.hi_busy;
			rd_byte[irq_funnel_pkg::ST_LO]  = q.lo_busy;
			rd_byte[irq_funnel_pkg::ST_REQ] = q.irq_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		s = q;

		// Software writes land first so that hardware sets win over clears
		if (wr_acc) begin
			if (paddr == irq_funnel_pkg::A_GCTL) begin
				s.gctl = pwdata[7:0];
			end else if (paddr == irq_funnel_pkg::A_ECTL) begin
				s.ectl = pwdata[7:0] & irq_funnel_pkg::ECTL_MASK; // see R16
			end else if (paddr == irq_funnel_pkg::A_XCTL) begin
				s.xctl = pwdata[7:0] & irq_funnel_pkg::XCTL_MASK; // see R16
			end else if (paddr == irq_funnel_pkg::A_PFLAG2) begin
				s.sbm_flag = pwdata[irq_funnel_pkg::PF_SBM];
			end else if (paddr == irq_funnel_pkg::A_PEN2) begin
				s.sbm_en = pwdata[irq_funnel_pkg::PF_SBM];
			end else if (paddr == irq_funnel_pkg::A_PPRI2) begin
				s.sbm_pri = pwdata[irq_funnel_pkg::PF_SBM]; // see R2
			end else if (paddr == irq_funnel_pkg::A_RSTCTL) begin
				s.prio_en = pwdata[irq_funnel_pkg::RC_PRIO]; // see R19
			end else if (paddr == irq_funnel_pkg::A_USBF) begin
				s.usb_flag = pwdata[irq_funnel_pkg::USB_N-1:0];
			end else if (paddr == irq_funnel_pkg::A_USBE) begin
				s.usb_en = pwdata[irq_funnel_pkg::USB_N-1:0];
			end
		end

		// Reading the port ends a mismatch by taking the value returned
		if (rd_acc && paddr == irq_funnel_pkg::A_PORT) begin
			s.port_latch = q.prdata_q[irq_funnel_pkg::PORT_N-1:0]; // see R11
		end

		// Hardware flag sets, independent of every enable except the USB source enables that feed bit 5
		s.gctl[irq_funnel_pkg::GC_T0F] = s.gctl[irq_funnel_pkg::GC_T0F]
		                                | timer_zero_overflow; // see R3 see R8
		s.gctl[irq_funnel_pkg::GC_X0F] = s.gctl[irq_funnel_pkg::GC_X0F]
		                                | ext_event[0]; // see R3 see R9
		// Flag is re-set every cycle while the mismatch lasts
		s.gctl[irq_funnel_pkg::GC_PCF] = s.gctl[irq_funnel_pkg::GC_PCF]
		                                | mismatch; // see R10 see R11
		s.xctl[irq_funnel_pkg::XC_X1F] = s.xctl[irq_funnel_pkg::XC_X1F]
		                                | ext_event[1]; // see R15
		s.xctl[irq_funnel_pkg::XC_X2F] = s.xctl[irq_funnel_pkg::XC_X2F]
		                                | ext_event[2]; // see R15
		s.usb_flag = s.usb_flag | serial_bus_events; // see R2 see R3
		usb_any    = |(q.usb_flag & q.usb_en);
		s.sbm_flag = s.sbm_flag | usb_any; // see R1

		// Accepting clears the enable of the level taken
		if (irq_ack && q.irq_q) begin
			if (q.vec_q == irq_funnel_pkg::VEC_HIGH) begin
				s.gctl[irq_funnel_pkg::GC_HIEN] = 1'b0; // see R21
				s.hi_busy = 1'b1;
			end else begin
				s.gctl[irq_funnel_pkg::GC_LOEN] = 1'b0; // see R21
				s.lo_busy = 1'b1;
			end
		end else if (return_from_irq_instr) begin
			// Return closes the innermost routine first
			if (q.hi_busy) begin
				s.hi_busy = 1'b0;
				s.gctl[irq_funnel_pkg::GC_HIEN] = 1'b1; // see R21
			end else if (q.lo_busy) begin
				s.lo_busy = 1'b0;
				s.gctl[irq_funnel_pkg::GC_LOEN] = 1'b1; // see R21
			end
		end

		// Per-source requests from the updated state
		src_t0  = s.gctl[irq_funnel_pkg::GC_T0F] & s.gctl[irq_funnel_pkg::GC_T0E]; // see R23
		src_x0  = s.gctl[irq_funnel_pkg::GC_X0F] & s.gctl[irq_funnel_pkg::GC_X0E]; // see R23
		src_pc  = s.gctl[irq_funnel_pkg::GC_PCF] & s.gctl[irq_funnel_pkg::GC_PCE]; // see R23
		src_x1  = s.xctl[irq_funnel_pkg::XC_X1F] & s.xctl[irq_funnel_pkg::XC_X1E]; // see R14
		src_x2  = s.xctl[irq_funnel_pkg::XC_X2F] & s.xctl[irq_funnel_pkg::XC_X2E]; // see R14
		src_usb = s.sbm_flag & s.sbm_en; // see R23

		// Line 0 has no priority bit and is always high
		any_hi = src_x0
		       | (src_t0 & s.ectl[irq_funnel_pkg::EC_T0P])
		       | (src_pc & s.ectl[irq_funnel_pkg::EC_PCP])
		       | (src_x1 & s.xctl[irq_funnel_pkg::XC_X1P])
		       | (src_x2 & s.xctl[irq_funnel_pkg::XC_X2P])
		       | (src_usb & s.sbm_pri); // see R13 see R14 see R2
		any_lo = (src_t0 & ~s.ectl[irq_funnel_pkg::EC_T0P])
		       | (src_pc & ~s.ectl[irq_funnel_pkg::EC_PCP])
		       | (src_x1 & ~s.xctl[irq_funnel_pkg::XC_X1P])
		       | (src_x2 & ~s.xctl[irq_funnel_pkg::XC_X2P])
		       | (src_usb & ~s.sbm_pri);

		if (s.prio_en) begin
			req_hi = s.gctl[irq_funnel_pkg::GC_HIEN] & any_hi; // see R5
			req_lo = s.gctl[irq_funnel_pkg::GC_LOEN] & any_lo & ~s.hi_busy; // see R7 see R22
		end else begin
			// Priority bits ignored; only the peripheral group sees bit 6
			req_hi = s.gctl[irq_funnel_pkg::GC_HIEN]
			       & (src_t0 | src_x0 | src_pc | src_x1 | src_x2
			       | (s.gctl[irq_funnel_pkg::GC_LOEN] & src_usb)); // see R4 see R6 see R19
			req_lo = 1'b0;
		end

		s.irq_q = req_hi | req_lo;
		s.vec_q = req_hi ? irq_funnel_pkg::VEC_HIGH : irq_funnel_pkg::VEC_LOW; // see R20

		s.pullup_q = s.ectl[irq_funnel_pkg::EC_PUD] ? '0 : port_out_latch; // see R17

		if (setup) begin
			s.prdata_q  = {{(irq_funnel_pkg::DATA_W-8){1'b0}}, rd_byte};
			s.pslverr_q = ~rd_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q      <= '0;
			q.gctl <= irq_funnel_pkg::GCTL_RST; // see R24
			q.ectl <= irq_funnel_pkg::ECTL_RST; // see R24
			q.xctl <= irq_funnel_pkg::XCTL_RST; // see R24
			q.vec_q <= irq_funnel_pkg::VEC_HIGH;
		end else begin
			q <= s;
		end
	end

	assign pready      = psel & penable;
	assign pslverr     = psel & penable & q.pslverr_q;
	assign prdata      = q.prdata_q;
	assign irq_request = q.irq_q;
	assign irq_vector  = q.vec_q;
	assign pullup_on   = q.pullup_q;
endmodule
`default_nettype wire

// >>> test/irq_funnel_properties.sv
// Port assertions for the interrupt funnel
`timescale 1ns/1ns
`default_nettype none
module irq_funnel_properties (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pull-ups and core side
	input wire logic [3:0]  port_out_latch,
	input wire logic [3:0]  pullup_on,
	input wire logic        irq_request,
	input wire logic [20:0] irq_vector,
	input wire logic        irq_ack,
	input wire logic        return_from_irq_instr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic rd;
	logic wr;
	assign acc = psel && penable;
	assign rd  = acc && !pwrite;
	assign wr  = acc && pwrite;
	a_ready_no_wait: assert property (pready == acc) else $error("pready not from psel and penable");
	a_err_unmapped: assert property (acc |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	a_read_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
	a_edge_unimpl_zero: assert property (rd && paddr == 8'h04 |-> !prdata[3] && !prdata[1])
		else $error("unimplemented edge register bit set");
	a_line_unimpl_zero: assert property (rd && paddr == 8'h08 |-> !prdata[5] && !prdata[2])
		else $error("unimplemented line register bit set");
	a_pullup_off: assert property (wr && paddr == 8'h04 && pwdata[7] |-> ##2 pullup_on == 4'h0)
		else $error("pull-ups not disabled");
	a_pullup_follow: assert property (wr && paddr == 8'h04 && !pwdata[7] |-> ##2
		pullup_on == $past(port_out_latch)) else $error("pull-ups not following latch");
	a_vector_legal: assert property (irq_request |-> irq_vector == 21'h000008 ||
		irq_vector == 21'h000018) else $error("illegal vector");
	a_high_accept_drop: assert property (irq_request && irq_ack && irq_vector == 21'h000008
		&& !wr && !return_from_irq_instr |=> !irq_request) else $error("request after high accept");
	a_low_accept_drop: assert property (irq_request && irq_ack && irq_vector == 21'h000018
		&& !wr && !return_from_irq_instr |=> !irq_request || irq_vector == 21'h000008)
		else $error("low request after low accept");
endmodule
bind core_interrupt_control_funnel irq_funnel_properties u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_out_latch, .pullup_on, .irq_request,
	.irq_vector, .irq_ack, .return_from_irq_instr);
`default_nettype wire

// >>> test/core_model.sv
// Processor core model: accepts requests after a delay and returns on command
`timescale 1ns/1ns
`default_nettype none
module core_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Funnel side
	input  wire logic        irq_request,
	input  wire logic [20:0] irq_vector,
	output logic             irq_ack,
	output logic             return_from_irq_instr,
	// Bench control and record
	input  wire logic [3:0]  ack_delay,
	input  wire logic        ret_cmd,
	output logic [7:0]       taken_cnt,
	output logic [20:0]      taken_vec
);
	logic [3:0] wait_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			return_from_irq_instr <= 1'b0;
			taken_cnt <= 8'h00;
			taken_vec <= 21'h000000;
			wait_q <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			return_from_irq_instr <= ret_cmd;
			if (irq_ack && irq_request) begin
				taken_cnt <= taken_cnt + 8'h01;
				taken_vec <= irq_vector;
			end
			// Accept only a request that is still up, after the chosen delay
			if (irq_request && !irq_ack) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= ack_delay) begin
					irq_ack <= 1'b1;
					wait_q <= 4'h0;
				end
			end else begin
				wait_q <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Register-level testbench for the interrupt funnel
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [7:0] GC = irq_funnel_pkg::A_GCTL;
	localparam logic [7:0] EC = irq_funnel_pkg::A_ECTL;
	localparam logic [7:0] XC = irq_funnel_pkg::A_XCTL;
	localparam logic [20:0] VH = irq_funnel_pkg::VEC_HIGH;
	localparam logic [20:0] VL = irq_funnel_pkg::VEC_LOW;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr, serial_bus_events, taken_cnt, nt;
	logic [31:0] pwdata, prdata, rdat;
	logic        timer_zero_overflow, irq_request, irq_ack, return_from_irq_instr, ret_cmd;
	logic [2:0]  ext_lines;
	logic [3:0]  upper_port_pins, port_out_latch, pullup_on, ack_delay;
	logic [20:0] irq_vector, taken_vec;
	int          fails, num_checks;
	core_interrupt_control_funnel uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .timer_zero_overflow, .serial_bus_events, .ext_lines,
		.upper_port_pins, .port_out_latch, .pullup_on, .irq_request, .irq_vector, .irq_ack,
		.return_from_irq_instr);
	core_model u_core (.pclk, .presetn, .irq_request, .irq_vector, .irq_ack, .return_from_irq_instr,
		.ack_delay, .ret_cmd, .taken_cnt, .taken_vec);
	always #10 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) fails++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic ev(input logic [7:0] u, input logic t);
		serial_bus_events <= u;
		timer_zero_overflow <= t;
		@(posedge pclk);
		serial_bus_events <= 8'h00;
		timer_zero_overflow <= 1'b0;
	endtask
	task automatic ret;
		ret_cmd <= 1'b1;
		@(posedge pclk);
		ret_cmd <= 1'b0;
		cyc(3);
	endtask
	task automatic take(input logic [20:0] v);
		int k;
		k = 0;
		nt++;
		while (taken_cnt !== nt && k < 40) begin
			k++;
			@(posedge pclk);
		end
		chk(32'(taken_cnt), 32'(nt));
		chk(32'(taken_vec), 32'(v));
	endtask
	task automatic lines(input logic [2:0] e);
		logic [2:0] f;
		xfer(1'b0, GC, 32'h0);
		f[0] = rdat[1];
		xfer(1'b0, XC, 32'h0);
		f[2:1] = rdat[1:0];
		chk(32'(f), 32'(e));
		wr(GC, 32'h0);
		wr(XC, 32'h0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, ret_cmd, nt} = '0;
		{timer_zero_overflow, serial_bus_events, ext_lines, upper_port_pins} = '0;
		port_out_latch = 4'hA;
		ack_delay = 4'h3;
		cyc(2);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(GC, 32'h00);
		rc(EC, 32'hF5);
		rc(XC, 32'hC0);
		chk(32'(pullup_on), 32'h0);
		wr(EC, 32'hFF);
		rc(EC, 32'hF5);
		wr(XC, 32'hFF);
		rc(XC, 32'hDB);
		rc(8'h2C, 32'h0);
		chk(32'(rerr), 32'h1);
		wr(8'h01, 32'hFF);
		chk(32'(rerr), 32'h1);
		rc(GC, 32'h00);
		chk(32'(rerr), 32'h0);
		wr(XC, 32'h0);
		wr(EC, 32'h75);
		chk(32'(pullup_on), 32'hA);
		ev(8'h00, 1'b1);
		cyc(3);
		rc(GC, 32'h04);
		chk(32'(taken_cnt), 32'(nt));
		for (int p = 0; p < 2; p++) begin
			wr(EC, p ? 32'h75 : 32'h05);
			ext_lines <= p ? 3'h0 : 3'h7;
			cyc(6);
			lines(3'h0);
			for (int i = 0; i < 3; i++) begin
				ext_lines <= ext_lines ^ (3'h1 << i);
				cyc(6);
				lines(3'(1 << i));
				ext_lines <= ext_lines ^ (3'h1 << i);
				cyc(6);
				lines(3'h0);
			end
		end
		upper_port_pins <= 4'h5;
		cyc(4);
		rc(GC, 32'h01);
		wr(GC, 32'h0);
		rc(GC, 32'h01);
		rc(irq_funnel_pkg::A_PORT, 32'h05);
		wr(GC, 32'h0);
		rc(GC, 32'h00);
		wr(GC, 32'hA0);
		ev(8'h00, 1'b1);
		take(VH);
		rc(GC, 32'h24);
		wr(GC, 32'h20);
		ret();
		rc(GC, 32'hA0);
		wr(irq_funnel_pkg::A_USBE, 32'h08);
		wr(irq_funnel_pkg::A_PEN2, 32'h20);
		ev(8'h08, 1'b0);
		cyc(3);
		rc(irq_funnel_pkg::A_USBF, 32'h08);
		rc(irq_funnel_pkg::A_PFLAG2, 32'h20);
		chk(32'(taken_cnt), 32'(nt));
		wr(GC, 32'hE0);
		take(VH);
		wr(irq_funnel_pkg::A_USBF, 32'h0);
		wr(irq_funnel_pkg::A_PFLAG2, 32'h0);
		ret();
		rc(GC, 32'hE0);
		wr(irq_funnel_pkg::A_RSTCTL, 32'h80);
		wr(EC, 32'h71);
		wr(GC, 32'hF0);
		ev(8'h00, 1'b1);
		take(VL);
		rc(GC, 32'hB4);
		ext_lines <= 3'h1;
		take(VH);
		rc(GC, 32'h36);
		wr(GC, 32'h74);
		cyc(6);
		chk(32'(taken_cnt), 32'(nt));
		ret();
		take(VL);
		wr(irq_funnel_pkg::A_PPRI2, 32'h20);
		ev(8'h08, 1'b0);
		take(VH);
		rc(irq_funnel_pkg::A_STATUS, 32'h03);
		report_and_stop();
	end
endmodule
`default_nettype wire
